/* core/pwm_ovr_pkg.sv */
package pwm_ovr_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_OVR = 8'h00;
  localparam logic [7:0] OFS_EVT = 8'h04;
  localparam logic [7:0] OFS_CON2 = 8'h08;
  localparam logic [7:0] OFS_PAIR = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // field positions
  localparam int OVR_SEL_LO = 8;
  localparam int EVT_DIR_BIT = 15;
  localparam int CON2_LOCK_BIT = 0;
  localparam int CON2_SYNC_BIT = 1;
  localparam int CON2_IUE_BIT = 2;
  localparam int CON2_HALTZ_BIT = 3;
  localparam int CON2_PS_LO = 8;
  localparam int STAT_PS_LO = 16;
  localparam int STAT_LOCK_BIT = 20;
  // writable bits and reset values
  localparam logic [15:0] CON2_MASK = 16'h0f0f;
  localparam logic [15:0] OVR_RST = 16'hff00;
  localparam logic [15:0] EVT_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h0000;
  localparam logic [3:0] PAIR_RST = 4'h0;
  // time base mode codes that count up and down
  localparam logic [1:0] TB_MODE_UPDOWN = 2'h2;
  localparam logic [1:0] TB_MODE_UPDOWN_DBL = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwm_ovr_pkg

/* core/ovr_lane_if.sv */
`timescale 1ns/1ps
interface ovr_lane_if #(parameter int N = 8);
  logic [N-1:0] sel;
  logic [N-1:0] level;
  logic [N-1:0] gen;
  logic [N/2-1:0] pair_mode;
  logic [N-1:0] pin;
  modport src (output sel, output level, output gen, output pair_mode, input pin);
  modport mixer (input sel, input level, input gen, input pair_mode, output pin);
endinterface : ovr_lane_if

/* core/override_mixer.sv */
`timescale 1ns/1ps
module override_mixer #(
  parameter int N = 8
) (
  // override lanes
  ovr_lane_if.mixer lane
);
  // per pair: even index is the low side, odd index the high side
  for (genvar p = 0; p < N / 2; p++) begin : g_pair
    logic hi_req;
    logic lo_req;
    // select high follows generator, low follows the manual level
    assign hi_req = lane.sel[2*p+1] ? lane.gen[2*p+1] : lane.level[2*p+1];
    assign lo_req = lane.sel[2*p] ? lane.gen[2*p] : lane.level[2*p];
    assign lane.pin[2*p+1] = hi_req;
    // complementary pairs: an active high side forces the low side off
    assign lane.pin[2*p] = lo_req & (lane.pair_mode[p] | ~hi_req);
  end
endmodule : override_mixer

/* core/event_postscaler.sv */
`timescale 1ns/1ps
module event_postscaler #(
  parameter int PS_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic clear,
  input wire logic tick,
  input wire logic [PS_W-1:0] ratio,
  // results
  output logic fire,
  output logic [PS_W-1:0] count
);
  logic [PS_W-1:0] cnt_q;
  logic [PS_W-1:0] cnt_d;
  logic fire_q;
  logic fire_d;

  // ratio code n passes one tick in n+1, code zero passes all;
  // a count left above a newly lowered ratio fires at once instead of wrapping
  always_comb begin
    fire_d = tick & (cnt_q >= ratio) & ~clear;
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (tick) begin
      cnt_d = (cnt_q >= ratio) ? '0 : PS_W'(cnt_q + 1'b1);
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      fire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fire_q <= fire_d;
    end
  end

  assign fire = fire_q;
  assign count = cnt_q;
endmodule : event_postscaler

/* core/pwm_override_event_lockout.sv */
`timescale 1ns/1ps
module pwm_override_event_lockout #(
  parameter int N_PINS = 8,
  parameter int CNT_W = 15,
  parameter int PS_W = 4
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // axi4-lite write address and data
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // time base state
  input wire logic [CNT_W-1:0] TB_COUNT,
  input wire logic [CNT_W-1:0] TB_PERIOD,
  input wire logic TB_DIR_DOWN,
  input wire logic [1:0] TB_MODE,
  input wire logic TB_ENABLE,
  // buffer transfer requests from the time base
  input wire logic DUTY_LOAD_REQ,
  input wire logic PERIOD_LOAD_REQ,
  // generator and dead time path
  input wire logic [N_PINS-1:0] PWM_GEN,
  output logic [N_PINS-1:0] OVR_OUT,
  input wire logic [N_PINS-1:0] DT_IN,
  // configuration bits and debugger
  input wire logic HIGH_SIDE_POLARITY,
  input wire logic LOW_SIDE_POLARITY,
  input wire logic PIN_DRIVE_AT_RESET,
  input wire logic DEBUG_HALT,
  // outputs
  output logic [N_PINS-1:0] PIN_OUT,
  output logic [N_PINS-1:0] PIN_OE,
  output logic EVENT_TRIGGER,
  output logic DUTY_LOAD_EN,
  output logic PERIOD_LOAD_EN
);
  // bus state
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic aw_fire, w_fire, ar_fire, do_wr;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ovr, wr_evt, wr_con2, wr_pair, wr_ok, rd_ok;
  logic [31:0] rd_mux;
  // register state
  logic [15:0] ovr_q, ovr_d, applied_q, applied_d, evt_q, evt_d, con2_q, con2_d;
  logic [3:0] pair_q, pair_d;
  logic sync_q, lock_q, haltz_q;
  // event and pin state
  logic match_q, match_d, at_pt_q, at_pt_d, match, at_pt, evt_hit, sync_pt, updown;
  logic [N_PINS-1:0] ovr_out_q, ovr_out_d, pin_q, pin_d, oe_q, oe_d, pol_mask;
  logic high_side_polarity_q, low_side_polarity_q, drive_q;
  logic [PS_W-1:0] ps_cnt;

  // byte lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  assign S_AXI_AWREADY = ~aw_hold_q & ~bvalid_q;
  assign S_AXI_WREADY = ~w_hold_q & ~bvalid_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  assign wr_addr = aw_hold_q ? aw_addr_q : S_AXI_AWADDR;
  assign wr_data = w_hold_q ? w_data_q : S_AXI_WDATA;
  assign wr_strb = w_hold_q ? w_strb_q : S_AXI_WSTRB;
  assign do_wr = (aw_hold_q | aw_fire) & (w_hold_q | w_fire);

  // write address decode
  always_comb begin
    wr_ovr = 1'b0;
    wr_evt = 1'b0;
    wr_con2 = 1'b0;
    wr_pair = 1'b0;
    wr_ok = 1'b1;
    if (wr_addr[7:2] == pwm_ovr_pkg::OFS_OVR[7:2]) begin
      wr_ovr = do_wr;
    end else if (wr_addr[7:2] == pwm_ovr_pkg::OFS_EVT[7:2]) begin
      wr_evt = do_wr;
    end else if (wr_addr[7:2] == pwm_ovr_pkg::OFS_CON2[7:2]) begin
      wr_con2 = do_wr;
    end else if (wr_addr[7:2] == pwm_ovr_pkg::OFS_PAIR[7:2]) begin
      wr_pair = do_wr;
    end else if (wr_addr[7:2] != pwm_ovr_pkg::OFS_STAT[7:2]) begin
      wr_ok = 1'b0;
    end
  end

  // read address decode; reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (S_AXI_ARADDR[7:2] == pwm_ovr_pkg::OFS_OVR[7:2]) begin
      rd_mux = {16'h0000, ovr_q};
    end else if (S_AXI_ARADDR[7:2] == pwm_ovr_pkg::OFS_EVT[7:2]) begin
      rd_mux = {16'h0000, evt_q};
    end else if (S_AXI_ARADDR[7:2] == pwm_ovr_pkg::OFS_CON2[7:2]) begin
      rd_mux = {16'h0000, con2_q};
    end else if (S_AXI_ARADDR[7:2] == pwm_ovr_pkg::OFS_PAIR[7:2]) begin
      rd_mux = {28'h0000000, pair_q};
    end else if (S_AXI_ARADDR[7:2] == pwm_ovr_pkg::OFS_STAT[7:2]) begin
      rd_mux[15:0] = applied_q;
      rd_mux[pwm_ovr_pkg::STAT_PS_LO +: PS_W] = ps_cnt;
      rd_mux[pwm_ovr_pkg::STAT_LOCK_BIT] = lock_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // bus handshake next state: address and data may arrive in either order
  always_comb begin
    aw_hold_d = do_wr ? 1'b0 : (aw_hold_q | aw_fire);
    w_hold_d = do_wr ? 1'b0 : (w_hold_q | w_fire);
    aw_addr_d = aw_fire ? S_AXI_AWADDR : aw_addr_q;
    w_data_d = w_fire ? S_AXI_WDATA : w_data_q;
    w_strb_d = w_fire ? S_AXI_WSTRB : w_strb_q;
    bvalid_d = do_wr | (bvalid_q & ~S_AXI_BREADY);
    bresp_d = do_wr ? (wr_ok ? pwm_ovr_pkg::RESP_OKAY : pwm_ovr_pkg::RESP_SLVERR) : bresp_q;
    rvalid_d = ar_fire | (rvalid_q & ~S_AXI_RREADY);
    rdata_d = ar_fire ? rd_mux : rdata_q;
    rresp_d = ar_fire ? (rd_ok ? pwm_ovr_pkg::RESP_OKAY : pwm_ovr_pkg::RESP_SLVERR) : rresp_q;
  end

  // bus registers
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= pwm_ovr_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pwm_ovr_pkg::RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  assign sync_q = con2_q[pwm_ovr_pkg::CON2_SYNC_BIT];
  assign lock_q = con2_q[pwm_ovr_pkg::CON2_LOCK_BIT];
  assign haltz_q = con2_q[pwm_ovr_pkg::CON2_HALTZ_BIT];

  // register next state and override application point
  always_comb begin
    ovr_d = wr_ovr ? merge16(ovr_q, wr_data, wr_strb) : ovr_q;
    evt_d = wr_evt ? merge16(evt_q, wr_data, wr_strb) : evt_q;
    con2_d = wr_con2 ? (merge16(con2_q, wr_data, wr_strb) & pwm_ovr_pkg::CON2_MASK) : con2_q;
    pair_d = (wr_pair & wr_strb[0]) ? wr_data[3:0] : pair_q;
    applied_d = (~sync_q | sync_pt) ? ovr_d : applied_q;
  end

  // register file
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ovr_q <= pwm_ovr_pkg::OVR_RST;
      applied_q <= pwm_ovr_pkg::OVR_RST;
      evt_q <= pwm_ovr_pkg::EVT_RST;
      con2_q <= pwm_ovr_pkg::CON2_RST;
      pair_q <= pwm_ovr_pkg::PAIR_RST;
    end else begin
      ovr_q <= ovr_d;
      applied_q <= applied_d;
      evt_q <= evt_d;
      con2_q <= con2_d;
      pair_q <= pair_d;
    end
  end

  // compare match and sync point, each taken once per count value
  assign updown = (TB_MODE == pwm_ovr_pkg::TB_MODE_UPDOWN) |
                  (TB_MODE == pwm_ovr_pkg::TB_MODE_UPDOWN_DBL);
  assign match = (TB_COUNT == evt_q[CNT_W-1:0]) &
                 (~updown | (TB_DIR_DOWN == evt_q[pwm_ovr_pkg::EVT_DIR_BIT]));
  assign at_pt = (TB_COUNT == '0) | (TB_COUNT == TB_PERIOD);
  assign evt_hit = match & ~match_q;
  assign sync_pt = at_pt & ~at_pt_q;

  // free-running trigger, no enable; compare write restarts postscaler
  event_postscaler #(.PS_W(PS_W)) u_post (
    .clk(CLK_SYS),
    .srst(SRST),
    .clear(wr_evt),
    .tick(evt_hit),
    .ratio(con2_q[pwm_ovr_pkg::CON2_PS_LO +: PS_W]),
    .fire(EVENT_TRIGGER),
    .count(ps_cnt)
  );

  // override mix of generator and manual levels
  ovr_lane_if #(.N(N_PINS)) lane ();
  assign lane.sel = applied_q[pwm_ovr_pkg::OVR_SEL_LO +: N_PINS];
  assign lane.level = applied_q[N_PINS-1:0];
  assign lane.gen = PWM_GEN;
  assign lane.pair_mode = pair_q;
  override_mixer #(.N(N_PINS)) u_mix (
    .lane(lane.mixer)
  );

  // polarity per side: odd pins are high side
  assign pol_mask = {(N_PINS/2){high_side_polarity_q, low_side_polarity_q}};

  // pin stage next state
  always_comb begin
    match_d = match;
    at_pt_d = at_pt;
    ovr_out_d = lane.pin;
    pin_d = ~(DT_IN ^ pol_mask);
    oe_d = ((drive_q | TB_ENABLE) & ~(DEBUG_HALT & haltz_q)) ? {N_PINS{1'b1}} : '0;
  end

  // pin stage registers; configuration bits caught while reset is held
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      match_q <= 1'b0;
      at_pt_q <= 1'b0;
      ovr_out_q <= '0;
      pin_q <= '0;
      oe_q <= '0;
      high_side_polarity_q <= HIGH_SIDE_POLARITY;
      low_side_polarity_q <= LOW_SIDE_POLARITY;
      drive_q <= PIN_DRIVE_AT_RESET;
    end else begin
      match_q <= match_d;
      at_pt_q <= at_pt_d;
      ovr_out_q <= ovr_out_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  assign OVR_OUT = ovr_out_q;
  assign PIN_OUT = pin_q;
  assign PIN_OE = oe_q;
  // transfers held while locked out
  assign DUTY_LOAD_EN = DUTY_LOAD_REQ & ~lock_q;
  assign PERIOD_LOAD_EN = PERIOD_LOAD_REQ & ~lock_q;

  // checks
  a_ovr_next_cycle: assert property (@(posedge CLK_SYS) disable iff (SRST)
    wr_ovr && !sync_q |=> applied_q == ovr_q) else $error("override not applied next cycle");
  a_ovr_sync_hold: assert property (@(posedge CLK_SYS) disable iff (SRST)
    sync_q && !sync_pt |=> $stable(applied_q)) else $error("override changed off sync point");
  a_ovr_sync_take: assert property (@(posedge CLK_SYS) disable iff (SRST)
    sync_q && sync_pt |=> applied_q == ovr_q) else $error("override missed sync point");
  a_pin_select_level: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (&pair_q) |=> OVR_OUT == (($past(lane.sel) & $past(PWM_GEN)) |
                              (~$past(lane.sel) & $past(lane.level))))
    else $error("override select mix wrong");
  for (genvar p = 0; p < N_PINS / 2; p++) begin : g_chk
    a_comp_guard: assert property (@(posedge CLK_SYS) disable iff (SRST)
      !$past(pair_q[p]) |-> !(OVR_OUT[2*p] && OVR_OUT[2*p+1]))
      else $error("both pins of complementary pair active");
  end
  a_evt_fire_one: assert property (@(posedge CLK_SYS) disable iff (SRST)
    evt_hit && !wr_evt && con2_q[pwm_ovr_pkg::CON2_PS_LO +: PS_W] == '0 |=> EVENT_TRIGGER)
    else $error("event trigger missing at 1:1");
  a_evt_direction: assert property (@(posedge CLK_SYS) disable iff (SRST)
    updown && (TB_DIR_DOWN != evt_q[pwm_ovr_pkg::EVT_DIR_BIT]) |-> !match)
    else $error("event matched on wrong count phase");
  a_evt_clear_cnt: assert property (@(posedge CLK_SYS) disable iff (SRST)
    wr_evt |=> ps_cnt == '0) else $error("postscaler not cleared by compare write");
  a_lockout_hold: assert property (@(posedge CLK_SYS) disable iff (SRST)
    lock_q |-> !DUTY_LOAD_EN && !PERIOD_LOAD_EN) else $error("transfer during lockout");
  a_halt_tristate: assert property (@(posedge CLK_SYS) disable iff (SRST)
    DEBUG_HALT && haltz_q |=> PIN_OE == '0) else $error("pins driven during debug halt");
  a_bresp_hold: assert property (@(posedge CLK_SYS) disable iff (SRST)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("write response dropped");
  c_sync_apply: cover property (@(posedge CLK_SYS) disable iff (SRST)
    sync_q && wr_ovr ##[1:50] sync_pt);
  c_evt_scaled: cover property (@(posedge CLK_SYS) disable iff (SRST)
    con2_q[pwm_ovr_pkg::CON2_PS_LO +: PS_W] != '0 && EVENT_TRIGGER);
  c_lock_release: cover property (@(posedge CLK_SYS) disable iff (SRST)
    lock_q ##1 !lock_q ##[0:20] DUTY_LOAD_EN);
endmodule : pwm_override_event_lockout

/* testbench/far_side_model.sv */
`timescale 1ns/1ps
module far_side_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // gate drive path through the dead time stage
  input wire logic [7:0] ovr,
  output logic [7:0] dt,
  // converter start input
  input wire logic trig,
  output logic [15:0] events
);
  logic [7:0] dt_q;
  logic [7:0] dt_d;
  logic [15:0] events_q;
  logic [15:0] events_d;
  // dead time stage with zero delay setting, converter counts every start pulse
  always_comb begin
    dt_d = ovr;
    events_d = events_q + {15'h0000, trig};
  end
  // state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      dt_q <= 8'h00;
      events_q <= 16'h0000;
    end else begin
      dt_q <= dt_d;
      events_q <= events_d;
    end
  end
  // while its input is still in reset the stage drives the inverse of its register
  assign dt = srst ? ~dt_q : dt_q;
  assign events = events_q;
endmodule : far_side_model

/* testbench/test_pwm_override_event_lockout.sv */
`timescale 1ns/1ps
module test_pwm_override_event_lockout;
  typedef struct {string nm; logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
  logic CLK_SYS = 1'b0;
  logic SRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, TB_DIR_DOWN;
  logic TB_ENABLE, DUTY_LOAD_REQ, PERIOD_LOAD_REQ, DUTY_LOAD_EN, PERIOD_LOAD_EN, EVENT_TRIGGER;
  logic HIGH_SIDE_POLARITY, LOW_SIDE_POLARITY, PIN_DRIVE_AT_RESET, DEBUG_HALT;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, PWM_GEN, OVR_OUT, DT_IN, PIN_OUT, PIN_OE, mx;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rng;
  logic [3:0] S_AXI_WSTRB, pm;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, TB_MODE;
  logic [14:0] TB_COUNT, TB_PERIOD;
  logic [15:0] events, e0, cur_ov;
  note_t notes[$];
  note_t nt;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  // block under test and its far side
  pwm_override_event_lockout DUT (
    .CLK_SYS, .SRST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .TB_COUNT, .TB_PERIOD, .TB_DIR_DOWN, .TB_MODE, .TB_ENABLE,
    .DUTY_LOAD_REQ, .PERIOD_LOAD_REQ, .PWM_GEN, .OVR_OUT, .DT_IN, .HIGH_SIDE_POLARITY,
    .LOW_SIDE_POLARITY, .PIN_DRIVE_AT_RESET, .DEBUG_HALT, .PIN_OUT, .PIN_OE,
    .EVENT_TRIGGER, .DUTY_LOAD_EN, .PERIOD_LOAD_EN
  );
  far_side_model far (.clk(CLK_SYS), .srst(SRST), .ovr(OVR_OUT), .dt(DT_IN),
    .trig(EVENT_TRIGGER), .events(events));

  // 40 MHz system clock
  always #12.5 CLK_SYS = ~CLK_SYS;

  // next value of the xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // expected override mix, high side winning in complementary pairs
  function automatic logic [7:0] mix(input logic [15:0] ov, input logic [7:0] g,
                                     input logic [3:0] p);
    logic [7:0] v;
    v = (ov[15:8] & g) | (~ov[15:8] & ov[7:0]);
    for (int i = 0; i < 4; i++) begin
      if (!p[i] && v[2*i+1]) begin
        v[2*i] = 1'b0;
      end
    end
    return v;
  endfunction : mix

  // compare one value and count it
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // print the counts and the verdict, then stop
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : tick

  // one cycle of time base count on the compare value
  task automatic hit(input logic down);
    TB_COUNT <= 15'h000a;
    TB_DIR_DOWN <= down;
    tick(1);
    TB_COUNT <= 15'h0005;
    tick(3);
  endtask : hit

  // bus write: address and data offered together, response awaited
  task automatic bus_write(input logic [7:0] a, input logic [15:0] d,
                           input logic [1:0] r = pwm_ovr_pkg::RESP_OKAY);
    notes.push_back('{"write response", 32'h0, 32'h0, r});
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {16'h0000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK_SYS);
  endtask : bus_write

  // bus read: expected data noted with a mask of the bits that matter
  task automatic bus_read(input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] m = 32'hffffffff,
                          input logic [1:0] r = pwm_ovr_pkg::RESP_OKAY);
    notes.push_back('{$sformatf("read %h", a), d, m, r});
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK_SYS);
  endtask : bus_read

  // monitor: each bus answer is checked against the oldest note
  always @(posedge CLK_SYS) begin
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      nt = notes.pop_front();
      check(nt.nm, {30'h0, S_AXI_BRESP}, {30'h0, nt.r});
    end
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      nt = notes.pop_front();
      check(nt.nm, {30'h0, S_AXI_RRESP}, {30'h0, nt.r});
      check(nt.nm, S_AXI_RDATA & nt.m, nt.d);
    end
  end

  // hang guard
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    {SRST, TB_ENABLE, PIN_DRIVE_AT_RESET, HIGH_SIDE_POLARITY} = 4'hf;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    {LOW_SIDE_POLARITY, DEBUG_HALT, TB_DIR_DOWN, DUTY_LOAD_REQ, PERIOD_LOAD_REQ} = 5'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, PWM_GEN, TB_MODE} = 26'h0;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    TB_COUNT = 15'h0005;
    TB_PERIOD = 15'h0014;
    rng = 32'h93f3458d;
    tick(16);
    SRST <= 1'b0;
    tick(1);
    bus_read(pwm_ovr_pkg::OFS_OVR, 32'h0000ff00);
    bus_read(pwm_ovr_pkg::OFS_EVT, 32'h0);
    bus_read(pwm_ovr_pkg::OFS_CON2, 32'h0);
    bus_read(8'h14, 32'h0, 32'hffffffff, pwm_ovr_pkg::RESP_SLVERR);
    bus_write(8'h18, 16'hffff, pwm_ovr_pkg::RESP_SLVERR);
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'hffff);
    bus_read(pwm_ovr_pkg::OFS_CON2, {16'h0, pwm_ovr_pkg::CON2_MASK});
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'h0000);
    $display("done: registers");
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      cur_ov = rng[15:0];
      // odd rounds keep every pair independent so the plain mix is exercised too
      pm = i[0] ? 4'hf : rng[19:16];
      PWM_GEN <= rng[27:20];
      bus_write(pwm_ovr_pkg::OFS_PAIR, {12'h000, pm});
      bus_write(pwm_ovr_pkg::OFS_OVR, cur_ov);
      mx = mix(cur_ov, PWM_GEN, pm);
      check("override mix", {24'h0, OVR_OUT}, {24'h0, mx});
      tick(3);
      check("pin level", {24'h0, PIN_OUT},
            {24'h0, mx ^ ~{4{HIGH_SIDE_POLARITY, LOW_SIDE_POLARITY}}});
    end
    $display("done: override");
    // time base stopped: only the drive-at-reset strap keeps the pins enabled
    TB_ENABLE <= 1'b0;
    tick(2);
    check("pin enable", {24'h0, PIN_OE}, 32'h000000ff);
    DEBUG_HALT <= 1'b1;
    tick(3);
    check("pin enable", {24'h0, PIN_OE}, 32'h000000ff);
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'h0008);
    tick(2);
    check("pin enable", {24'h0, PIN_OE}, 32'h00000000);
    DEBUG_HALT <= 1'b0;
    tick(2);
    check("pin enable", {24'h0, PIN_OE}, 32'h000000ff);
    $display("done: halt");
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'h0002);
    bus_write(pwm_ovr_pkg::OFS_OVR, 16'h00a5);
    tick(2);
    bus_read(pwm_ovr_pkg::OFS_STAT, {16'h0, cur_ov}, 32'h0000ffff);
    TB_COUNT <= 15'h0014;
    tick(1);
    TB_COUNT <= 15'h0005;
    bus_read(pwm_ovr_pkg::OFS_STAT, 32'h000000a5, 32'h0000ffff);
    bus_write(pwm_ovr_pkg::OFS_OVR, 16'h5a5a);
    tick(2);
    bus_read(pwm_ovr_pkg::OFS_STAT, 32'h000000a5, 32'h0000ffff);
    TB_COUNT <= 15'h0000;
    tick(1);
    TB_COUNT <= 15'h0005;
    bus_read(pwm_ovr_pkg::OFS_STAT, 32'h00005a5a, 32'h0000ffff);
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'h0000);
    bus_write(pwm_ovr_pkg::OFS_OVR, 16'hff00);
    bus_read(pwm_ovr_pkg::OFS_STAT, 32'h0000ff00, 32'h0000ffff);
    $display("done: sync");
    DUTY_LOAD_REQ <= 1'b1;
    PERIOD_LOAD_REQ <= 1'b1;
    tick(1);
    check("load enables", {30'h0, DUTY_LOAD_EN, PERIOD_LOAD_EN}, 32'h3);
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'h0001);
    check("load enables", {30'h0, DUTY_LOAD_EN, PERIOD_LOAD_EN}, 32'h0);
    bus_read(pwm_ovr_pkg::OFS_STAT, 32'h00100000, 32'h00100000);
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'h0000);
    check("load enables", {30'h0, DUTY_LOAD_EN, PERIOD_LOAD_EN}, 32'h3);
    $display("done: lockout");
    for (int md = 0; md < 4; md++) begin
      TB_MODE <= md[1:0];
      bus_write(pwm_ovr_pkg::OFS_EVT, 16'h800a);
      e0 = events;
      hit(1'b0);
      check("up phase", {16'h0, events - e0}, (md >= 2) ? 32'd0 : 32'd1);
      hit(1'b1);
      check("down phase", {16'h0, events - e0}, (md >= 2) ? 32'd1 : 32'd2);
    end
    TB_MODE <= 2'h0;
    for (int k = 0; k < 16; k++) begin
      bus_write(pwm_ovr_pkg::OFS_CON2, {4'h0, k[3:0], 8'h00});
      bus_write(pwm_ovr_pkg::OFS_EVT, 16'h000a);
      e0 = events;
      repeat (2 * k + 1) hit(1'b0);
      check("scaled events", {16'h0, events - e0}, 32'd1);
      hit(1'b0);
      check("scaled events", {16'h0, events - e0}, 32'd2);
    end
    bus_write(pwm_ovr_pkg::OFS_CON2, 16'h0300);
    bus_write(pwm_ovr_pkg::OFS_EVT, 16'h000a);
    e0 = events;
    repeat (2) hit(1'b0);
    bus_write(pwm_ovr_pkg::OFS_EVT, 16'h000a);
    repeat (3) hit(1'b0);
    check("cleared scaler", {16'h0, events - e0}, 32'd0);
    hit(1'b0);
    check("cleared scaler", {16'h0, events - e0}, 32'd1);
    $display("done: event trigger");
    tally_and_finish();
  end
endmodule : test_pwm_override_event_lockout
